// ### slc_line_ctrl.sv
// Line card controller driving a ringing line interface circuit over its pins.
// Assumes hook and unbalance pins are asynchronous; sys_clk is 20 MHz.
//
// Functional notes
// R1 - Device: hook high off hook, low on hook
// R2 - Device: dial digits are low pulses on hook
// R3 - Debounce hook status before use
// R4 - Unbalance over 5 s: power down, poll 5 s
// R5 - Mask unbalance while ringing control active
// R6 - Power-up: power down high 100 ms, then low
// R7 - Ring control high only with 20 Hz wave
// R8 - Device: trips ringing on off hook itself
// R9 - Controller drops ring control after trip
// R10 - Device: hook output glitch free around ringing
// R11 - Reversal only on request; else low
// R12 - Device: hook still reported while powered down
// R13 - Hook while powered down: drive power down low; code does this only asleep, not in power-up or fault
// R14 - Mask about 80 ms break after wake
// R15 - Meter gate is independent control
// R16 - Meter gate high only when metering requested
// R17 - Device: ring control low means normal feed
// R18 - Synchronise status pins before timing them
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module slc_line_ctrl
  import slc_pkg::*;
#(
  parameter int unsigned UNBAL_CYC  = `SLC_MS_CYC(`SLC_UNBAL_MS),
  parameter int unsigned POLL_CYC   = `SLC_MS_CYC(`SLC_POLL_MS),
  parameter int unsigned PWRUP_CYC  = `SLC_MS_CYC(`SLC_PWRUP_MS),
  parameter int unsigned WAKE_CYC   = `SLC_MS_CYC(`SLC_WAKE_MASK_MS),
  parameter int unsigned DEB_CYC    = `SLC_MS_CYC(`SLC_DEBOUNCE_MS),
  parameter int unsigned RHALF_CYC  = `SLC_RING_HALF_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // User requests
  input  wire logic ring_req,
  input  wire logic reverse_req,
  input  wire logic meter_req,
  input  wire logic sleep_req,
  // User status
  output var  logic off_hook,
  output var  logic hook_edge,
  output var  logic dial_pulse,
  output var  logic ring_tripped,
  output var  logic unbal_fault,
  output var  logic line_ready,
  // Device pins, inputs
  input  wire logic hook_state_out,
  input  wire logic unbalance_flag,
  // Device pins, outputs
  output var  logic power_down_in,
  output var  logic ring_control_in,
  output var  logic ring_wave_in,
  output var  logic polarity_reverse_in,
  output var  logic meter_pulse_gate
);
  localparam int unsigned TW = 32;

  slc_deb_if hk ();
  slc_deb_if ub ();

  // ---------------------------------------------------------------
  // Status pin conditioning
  // ---------------------------------------------------------------
  // Both pins pass a synchroniser and a stability filter
  assign hk.raw = hook_state_out; // R18
  assign ub.raw = unbalance_flag; // R18

  slc_debounce #(.STABLE_CYC(DEB_CYC)) u_hook_deb ( // R3
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       (hk)
  );

  slc_debounce #(.STABLE_CYC(DEB_CYC)) u_unbal_deb (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       (ub)
  );

  // ---------------------------------------------------------------
  // Supervisor state machine
  // ---------------------------------------------------------------
  slc_state_t    st_q;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] ub_cnt_q;
  logic          hook_ok;
  logic          ub_seen;
  logic          off_hook_seen_q;

  // Hook is only trusted when the device is awake and past the wake gap
  assign hook_ok = (st_q == SLC_ST_IDLE);
  // Unbalance ignored during ringing, its readings are meaningless then
  assign ub_seen = ub.clean && !ring_control_in; // R5

  // State and the shared interval timer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= SLC_ST_PWRUP;
      tmr_q <= '0;
    end else begin
      case (st_q)
        SLC_ST_PWRUP: begin
          if (tmr_q == TW'(PWRUP_CYC - 1)) begin // R6
            st_q  <= SLC_ST_IDLE;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        SLC_ST_IDLE: begin
          tmr_q <= '0;
          if (ub_cnt_q == TW'(UNBAL_CYC)) begin // R4
            st_q <= SLC_ST_FAULT;
          end else if (sleep_req && !hk.clean && !ring_req) begin
            st_q <= SLC_ST_SLEEP;
          end
        end
        SLC_ST_SLEEP: begin
          tmr_q <= '0;
          // Device still reports off hook asleep
          if (hk.clean || !sleep_req) begin // R13
            st_q <= SLC_ST_WAKE;
          end
        end
        SLC_ST_WAKE: begin
          // Hook break while the loop powers up is hidden
          if (tmr_q == TW'(WAKE_CYC - 1)) begin // R14
            st_q  <= SLC_ST_IDLE;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        SLC_ST_FAULT: begin
          // Held down for one poll interval, then woken through the wake gap into idle to recheck
          if (tmr_q == TW'(POLL_CYC - 1)) begin // R4
            st_q  <= SLC_ST_WAKE;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        default: begin
          st_q  <= SLC_ST_PWRUP;
          tmr_q <= '0;
        end
      endcase
    end
  end

  // Unbalance duration counter, saturates at the limit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ub_cnt_q <= '0;
    end else if (!ub_seen || st_q != SLC_ST_IDLE) begin
      ub_cnt_q <= '0;
    end else if (ub_cnt_q != TW'(UNBAL_CYC)) begin
      ub_cnt_q <= ub_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Ringing
  // ---------------------------------------------------------------
  logic [TW-1:0] rw_cnt_q;
  logic          trip_q;

  // Wave runs whenever ringing is enabled; square wave at 20 Hz
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rw_cnt_q     <= '0;
      ring_wave_in <= 1'b0;
    end else if (!ring_control_in) begin
      rw_cnt_q     <= '0;
      ring_wave_in <= 1'b0;
    end else if (rw_cnt_q == TW'(RHALF_CYC - 1)) begin
      rw_cnt_q     <= '0;
      ring_wave_in <= !ring_wave_in; // R7
    end else begin
      rw_cnt_q <= rw_cnt_q + 1'b1;
    end
  end

  // Trip latch; cleared only when the user drops the request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trip_q <= 1'b0;
    end else if (ring_control_in && hk.clean) begin
      trip_q <= 1'b1; // R9
    end else if (!ring_req) begin
      trip_q <= 1'b0;
    end
  end

  // Ring control only when awake, on hook and not tripped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ring_control_in <= 1'b0;
    end else begin
      ring_control_in <= ring_req && hook_ok && !trip_q && !hk.clean; // R7 R9
    end
  end

  // ---------------------------------------------------------------
  // Pin and status registers
  // ---------------------------------------------------------------
  // Power down high at power-up, asleep and in fault
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_down_in <= 1'b1; // R6
    end else begin
      power_down_in <= (st_q == SLC_ST_PWRUP) || (st_q == SLC_ST_SLEEP) ||
                       (st_q == SLC_ST_FAULT); // R4 R13
    end
  end

  // Reversal and metering follow requests only when awake
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      polarity_reverse_in <= 1'b0;
      meter_pulse_gate    <= 1'b0;
    end else begin
      polarity_reverse_in <= reverse_req && hook_ok; // R11
      meter_pulse_gate    <= meter_req && hook_ok; // R15 R16
    end
  end

  // User status, hook events only in trusted state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      off_hook     <= 1'b0;
      hook_edge    <= 1'b0;
      dial_pulse   <= 1'b0;
      ring_tripped <= 1'b0;
      unbal_fault  <= 1'b0;
      line_ready   <= 1'b0;
    end else begin
      off_hook     <= hk.clean;
      hook_edge    <= hk.changed && hook_ok; // R3
      dial_pulse   <= hk.changed && hk.clean && hook_ok && off_hook_seen_q;
      ring_tripped <= trip_q;
      unbal_fault  <= (st_q == SLC_ST_FAULT);
      line_ready   <= hook_ok;
    end
  end

  // Remembers a settled off hook so a return marks a dial break end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      off_hook_seen_q <= 1'b0;
    end else if (!hook_ok) begin
      off_hook_seen_q <= 1'b0;
    end else if (hk.changed && hk.clean) begin
      off_hook_seen_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_pwrup_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    (st_q == SLC_ST_PWRUP && tmr_q == '0) |=> power_down_in)
    else $error("power down not held at start");
  a_ring_mask: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    ring_control_in |-> ub_cnt_q == '0 || $past(ring_control_in) == 1'b0)
    else $error("unbalance counted during ringing");
  a_trip_drop: assert property (@(posedge sys_clk) disable iff (!rstn) // R9
    (ring_control_in && hk.clean) |=> ##1 !ring_control_in)
    else $error("ring control kept after trip");
  a_sleep_wake: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    (st_q == SLC_ST_SLEEP && hk.clean) |=> ##1 !power_down_in)
    else $error("no wake on hook in sleep");
  a_wake_mask: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    (st_q == SLC_ST_WAKE) |-> !hook_edge ##0 !ring_control_in)
    else $error("hook used in wake gap");
  a_fault_pd: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    (st_q == SLC_ST_FAULT) |=> power_down_in)
    else $error("fault without power down");
  a_rev_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    !reverse_req |=> !polarity_reverse_in)
    else $error("reversal without request");
  a_meter_gate: assert property (@(posedge sys_clk) disable iff (!rstn) // R16
    !meter_req |=> !meter_pulse_gate)
    else $error("meter gate without request");
  a_wave_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    !ring_control_in |=> !ring_wave_in)
    else $error("ring wave without ring control");
  a_unbal_mask: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    ring_control_in |=> ub_cnt_q == '0)
    else $error("unbalance timed while ringing");
  // Covers for ringing, fault, wake, dialling and masked unbalance
  c_ring: cover property (@(posedge sys_clk) disable iff (!rstn) ring_control_in ##1 trip_q);
  c_fault: cover property (@(posedge sys_clk) disable iff (!rstn) st_q == SLC_ST_FAULT);
  c_wake: cover property (@(posedge sys_clk) disable iff (!rstn)
    st_q == SLC_ST_SLEEP ##1 st_q == SLC_ST_WAKE);
  c_dial: cover property (@(posedge sys_clk) disable iff (!rstn) dial_pulse);
  c_mask: cover property (@(posedge sys_clk) disable iff (!rstn) ring_control_in && ub.clean);
endmodule : slc_line_ctrl
`default_nettype wire

// ### slc_regs.svh
// Timing constants for the line supervision controller.
// Assumes a 20 MHz system clock; all counts derive from it.
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH
`define SLC_CLK_HZ          20000000
`define SLC_UNBAL_MS        5000
`define SLC_POLL_MS         5000
`define SLC_PWRUP_MS        100
`define SLC_WAKE_MASK_MS    80
`define SLC_DEBOUNCE_MS     10
`define SLC_RING_HZ         20
`define SLC_MS_CYC(ms)      ((ms) * (`SLC_CLK_HZ / 1000))
`define SLC_RING_HALF_CYC   (`SLC_CLK_HZ / (2 * `SLC_RING_HZ))
`endif

// ### slc_pkg.sv
// Types for the line supervision controller.
// Assumes slc_regs.svh is compiled alongside.
`default_nettype none
package slc_pkg;
  typedef enum logic [2:0] {
    SLC_ST_PWRUP = 3'b000,
    SLC_ST_IDLE  = 3'b001,
    SLC_ST_SLEEP = 3'b010,
    SLC_ST_WAKE  = 3'b011,
    SLC_ST_FAULT = 3'b100
  } slc_state_t;
endpackage : slc_pkg
`default_nettype wire

// ### slc_deb_if.sv
// Bundle between the controller and its debouncer.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface slc_deb_if;
  logic raw;
  logic clean;
  logic changed;
  modport ctl (input clean, input changed, output raw);
  modport deb (input raw, output clean, output changed);
endinterface : slc_deb_if
`default_nettype wire

// ### slc_debounce.sv
// Synchroniser plus debouncer for one device status pin.
// Assumes an asynchronous pin on raw; clean changes only after a stable run.
`timescale 1ns/1ps
`default_nettype none
module slc_debounce #(
  parameter int unsigned STABLE_CYC = 200000
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Filtered pin
  slc_deb_if.deb    d
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  logic          s1_q, s2_q;
  logic [CW-1:0] cnt_q;
  logic          clean_q, chg_q;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= d.raw;
      s2_q <= s1_q;
    end
  end

  // Stability counter; any return to the clean level restarts it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q   <= '0;
      clean_q <= 1'b0;
      chg_q   <= 1'b0;
    end else begin
      chg_q <= 1'b0;
      if (s2_q == clean_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
        cnt_q   <= '0;
        clean_q <= s2_q;
        chg_q   <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign d.clean   = clean_q;
  assign d.changed = chg_q;
endmodule : slc_debounce
`default_nettype wire

// ### slc_dev_model.sv
// Behavioural model of the line interface circuit seen from its logic pins.
// Assumes the bench sets phone and unbalance states on phone_off and unbal_cmd.
`timescale 1ns/1ps
`default_nettype none
module slc_dev_model #(
  parameter int BRK_NS = 1000
) (
  // Control pins from the controller
  input  wire logic power_down_in,
  input  wire logic ring_control_in,
  input  wire logic ring_wave_in,
  input  wire logic polarity_reverse_in,
  input  wire logic meter_pulse_gate,
  // Line conditions set by the bench
  input  wire logic phone_off,
  input  wire logic unbal_cmd,
  // Status pins to the controller, ringing_live to the bench
  output var  logic hook_state_out,
  output var  logic unbalance_flag,
  output var  logic ringing_live
);
  logic trip_q;
  logic brk;
  // --------------------------------------------------------------
  // Ring trip and feed mode
  // --------------------------------------------------------------
  // Trip holds until ring control drops; the model never re-rings by itself
  always @(ring_control_in or phone_off) begin
    if (!ring_control_in)
      trip_q = 1'b0;
    else if (phone_off)
      trip_q = 1'b1;
  end
  assign ringing_live = ring_control_in & ~trip_q & ~power_down_in & ring_wave_in;
  // --------------------------------------------------------------
  // Status pins
  // --------------------------------------------------------------
  // Loop takes time to power up, so hook reads low briefly after waking
  initial brk = 1'b0;
  always @(negedge power_down_in) begin
    brk = 1'b1;
    #BRK_NS brk = 1'b0;
  end
  // Ring control and a held power-down do not disturb the hook pin; only the power-down release breaks it
  assign hook_state_out = phone_off & ~brk;
  assign unbalance_flag = unbal_cmd;
endmodule : slc_dev_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the line supervision controller.
// Assumes the device model and shortened timing parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PW = 50, WK = 40, UB = 200, PL = 200;
  logic sys_clk, rstn, ring_req, reverse_req, meter_req, sleep_req, phone_off, unbal_cmd;
  logic off_hook, hook_edge, dial_pulse, ring_tripped, unbal_fault, line_ready, ringing_live;
  logic hook_state_out, unbalance_flag, power_down_in, ring_control_in, ring_wave_in;
  logic polarity_reverse_in, meter_pulse_gate;
  int   n_fail, checks, n_dial, n_edge;
  // --------------------------------------------------------------
  // Design, device model, clock
  // --------------------------------------------------------------
  slc_line_ctrl #(.UNBAL_CYC(UB), .POLL_CYC(PL), .PWRUP_CYC(PW), .WAKE_CYC(WK), .DEB_CYC(4),
    .RHALF_CYC(10)) dut_u (.sys_clk, .rstn, .ring_req, .reverse_req, .meter_req, .sleep_req,
    .off_hook, .hook_edge, .dial_pulse, .ring_tripped, .unbal_fault, .line_ready, .hook_state_out,
    .unbalance_flag, .power_down_in, .ring_control_in, .ring_wave_in, .polarity_reverse_in,
    .meter_pulse_gate);
  slc_dev_model dev_u (.power_down_in, .ring_control_in, .ring_wave_in, .polarity_reverse_in,
    .meter_pulse_gate, .phone_off, .unbal_cmd, .hook_state_out, .unbalance_flag, .ringing_live);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // One-cycle pulses, counted at the falling edge where they are settled
  always @(negedge sys_clk) begin
    if (dial_pulse === 1'b1) n_dial++;
    if (hook_edge === 1'b1) n_edge++;
  end
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // Bounded wait on one output; running out ends the run as a mismatch
  task automatic wait_for(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      case (sel)
        0: s = power_down_in;
        1: s = ring_control_in;
        2: s = off_hook;
        3: s = unbal_fault;
        default: s = line_ready;
      endcase
      if (s === v) return;
      @(negedge sys_clk);
    end
    chk(sel, 32'hff);
    end_of_test();
  endtask : wait_for
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_pwrup();
    chk(power_down_in, 1);
    cyc(PW - 5);
    chk(power_down_in, 1);
    wait_for(0, 1'b0, 10);
    wait_for(4, 1'b1, 5);
    chk({polarity_reverse_in, meter_pulse_gate, ring_control_in}, 0);
  endtask : t_pwrup
  task automatic t_revmeter();
    reverse_req = 1; cyc(2);
    chk({polarity_reverse_in, meter_pulse_gate}, 2'b10);
    meter_req = 1; cyc(2);
    chk({polarity_reverse_in, meter_pulse_gate}, 2'b11);
    reverse_req = 0; cyc(2);
    chk({polarity_reverse_in, meter_pulse_gate}, 2'b01);
    meter_req = 0; cyc(2);
    chk(meter_pulse_gate, 0);
  endtask : t_revmeter
  task automatic t_dial();
    phone_off = 1; wait_for(2, 1'b1, 30);
    cyc(1);
    n_dial = 0;
    n_edge = 0;
    phone_off = 0; cyc(2); phone_off = 1; cyc(20);
    chk(n_dial, 0);
    phone_off = 0; cyc(15); phone_off = 1; cyc(20);
    chk(n_dial, 1);
    chk(n_edge, 2);
    phone_off = 0; wait_for(2, 1'b0, 30);
  endtask : t_dial
  task automatic t_ring();
    int n;
    logic w;
    ring_req = 1; wait_for(1, 1'b1, 3);
    n = 0; w = ring_wave_in;
    repeat (40) begin
      cyc(1);
      if (ring_wave_in !== w) n++;
      w = ring_wave_in;
    end
    chk(n, 4);
    unbal_cmd = 1; cyc(UB + 20);
    chk(unbal_fault, 0);
    phone_off = 1; cyc(1);
    chk({ring_control_in, ringing_live}, 2'b10);
    wait_for(1, 1'b0, 30);
    unbal_cmd = 0; cyc(2);
    chk(ring_tripped, 1);
    ring_req = 0; cyc(3);
    chk(ring_tripped, 0);
    phone_off = 0; wait_for(2, 1'b0, 30);
  endtask : t_ring
  task automatic t_unbal();
    unbal_cmd = 1; cyc(UB - 5);
    chk(unbal_fault, 0);
    wait_for(3, 1'b1, 20); cyc(1);
    chk(power_down_in, 1);
    cyc(PL - 10);
    chk(power_down_in, 1);
    wait_for(0, 1'b0, 20);
    unbal_cmd = 0; wait_for(4, 1'b1, WK + 20);
    chk(unbal_fault, 0);
  endtask : t_unbal
  task automatic t_sleep();
    sleep_req = 1; wait_for(0, 1'b1, 5);
    n_dial = 0;
    n_edge = 0;
    phone_off = 1; wait_for(0, 1'b0, 30);
    wait_for(4, 1'b1, WK + 10); cyc(2);
    chk({off_hook, n_dial[3:0]}, 5'h10);
    chk(n_edge, 0);
    sleep_req = 0; phone_off = 0; wait_for(2, 1'b0, 30);
  endtask : t_sleep
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {rstn, ring_req, reverse_req, meter_req, sleep_req, phone_off, unbal_cmd} = '0;
    n_fail = 0; checks = 0; n_dial = 0; n_edge = 0;
    cyc(8);
    rstn = 1;
    t_pwrup();
    t_revmeter();
    t_dial();
    t_ring();
    t_unbal();
    t_sleep();
    // Mid-run reset must restart the power-up hold
    rstn = 0; cyc(8);
    rstn = 1;
    t_pwrup();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
